// file: rtl/draw_engine_pkg.sv
// constants for the drawing co-processor setup register bank
// assumes an apb slave on pclk; printed offsets are register indices, byte address = index * 4
package draw_engine_pkg;
	// register indices (byte address is index * 4)
	localparam logic [7:0] REG_CONTROL_ONE   = 8'h10;
	localparam logic [7:0] REG_MAP_SELECT    = 8'h12;
	localparam logic [7:0] REG_QUEUE_STATUS  = 8'h13;
	localparam logic [7:0] REG_MAP_BASE      = 8'h14;
	localparam logic [7:0] REG_MAP_WIDTH     = 8'h18;
	localparam logic [7:0] REG_MAP_HEIGHT    = 8'h1a;
	localparam logic [7:0] REG_MAP_FORMAT    = 8'h1c;
	localparam logic [7:0] REG_LINE_ERROR    = 8'h20;
	localparam logic [7:0] REG_LINE_CONST1   = 8'h24;
	localparam logic [7:0] REG_LINE_CONST2   = 8'h28;
	localparam logic [7:0] REG_STEP_LAUNCH   = 8'h2c;

	// control one fields
	localparam int CTL_IRQ_EN   = 0;
	localparam int CTL_MASTER   = 1;
	localparam int CTL_IRQ_STAT = 4;
	localparam int CTL_TERM     = 5;
	localparam int CTL_TURBO    = 6;
	localparam int CTL_FAST     = 7;
	localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;

	// queue status fields
	localparam int QS_OVERFLOW = 7;
	localparam logic QS_OVERFLOW_RESET = 1'b0;

	// map format fields and depth codes
	localparam int FMT_BIG_ENDIAN = 3;
	localparam int FMT_SYSMEM     = 7;
	localparam logic [2:0] DEPTH_1BPP  = 3'h0;
	localparam logic [2:0] DEPTH_8BPP  = 3'h3;
	localparam logic [2:0] DEPTH_16BPP = 3'h4;
	localparam logic [2:0] DEPTH_32BPP = 3'h5;
	localparam logic [1:0] MAP_MASK    = 2'h0;

	// field widths
	localparam int DIM_W  = 12;
	localparam int LINE_W = 14;

	// step code fields
	localparam int CODE_DRAW = 4;
	localparam int CODE_DIR  = 5;
	localparam logic [7:0] CODE_STOP = 8'h00;
	localparam logic [1:0] LAST_CODE = 2'h3;

	// engine states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LOAD = 4'b0010,
		ST_RUN  = 4'b0100,
		ST_GAP  = 4'b1000
	} engine_state_t;
endpackage

// file: rtl/draw_engine_setup_regs.sv
// setup registers, command queue and draw-and-step sequencer of the drawing co-processor
// assumes a single apb4 master on pclk; pixel writes go to a datapath outside this block
`timescale 1ns/1ns
`default_nettype none
module draw_engine_setup_regs
	import draw_engine_pkg::*;
#(
	parameter int QUEUE_DEPTH = 8,
	parameter int POS_W       = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [9:0]       paddr,
	input  wire logic [31:0]      pwdata,
	input  wire logic [3:0]       pstrb,
	output logic                  pready,
	output logic [31:0]           prdata,
	output logic                  pslverr,
	output logic                  engine_done_irq_pin_n,
	output logic                  legacy_irq_pin_n,
	output logic                  master_mode_en,
	output logic                  turbo_en,
	output logic                  fast_addr_en,
	output logic                  engine_busy,
	output logic                  pixel_write,
	output logic [POS_W-1:0]      pixel_x,
	output logic [POS_W-1:0]      pixel_y,
	output logic [2:0]            sel_map_depth
);
	localparam int PTR_W = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
	localparam logic [4:0] DEPTH_COUNT = 5'(QUEUE_DEPTH);

	typedef struct packed {
		logic                           rdy;
		logic [31:0]                    rdata;
		logic                           err;
		logic                           rd_ovf;
		logic [7:0]                     control;
		logic [1:0]                     map_sel;
		logic                           overflow;
		logic [3:0][31:0]               base;
		logic [3:0][DIM_W-1:0]          width;
		logic [3:0][DIM_W-1:0]          height;
		logic [3:0][7:0]                format;
		logic [LINE_W-1:0]              line_err;
		logic [LINE_W-1:0]              line_one;
		logic [LINE_W-1:0]              line_two;
		logic [31:0]                    steps;
		logic [QUEUE_DEPTH-1:0][31:0]   queue;
		logic [PTR_W-1:0]               wr_ptr;
		logic [PTR_W-1:0]               rd_ptr;
		logic [4:0]                     count;
		engine_state_t                  state;
		logic [31:0]                    word;
		logic [1:0]                     code_idx;
		logic [3:0]                     steps_left;
		logic                           pix;
		logic [POS_W-1:0]               x;
		logic [POS_W-1:0]               y;
		logic [2:0]                     depth;
		logic                           busy;
		logic                           irq_done_n;
		logic                           irq_legacy_n;
	} regs_t;

	regs_t r;
	regs_t next_r;

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction

	// unit x/y step for each of the eight directions, counter-clockwise from +x
	function automatic logic [1:0] dir_dx(input logic [2:0] d);
		unique case (d)
			3'h0, 3'h1, 3'h7: return 2'b01;
			3'h3, 3'h4, 3'h5: return 2'b11;
			3'h2, 3'h6:       return 2'b00;
		endcase
	endfunction

	function automatic logic [1:0] dir_dy(input logic [2:0] d);
		unique case (d)
			3'h1, 3'h2, 3'h3: return 2'b11;
			3'h5, 3'h6, 3'h7: return 2'b01;
			3'h0, 3'h4:       return 2'b00;
		endcase
	endfunction

	// bus decode and sequencer helper nets
	logic [7:0] widx;
	logic       setup;
	logic       done;
	logic       wr;
	logic       rd;
	logic       push;
	logic       pop;
	logic       complete;
	logic [7:0] cur_code;
	logic [3:0] free_n;
	logic [2:0] cur_dir;
	logic [1:0] dx;
	logic [1:0] dy;

	// apb phase decode; a transfer completes on the access edge
	assign widx   = paddr[9:2];
	assign setup  = psel & ~penable;
	assign done   = psel & penable & r.rdy;
	assign wr     = done & pwrite;
	assign rd     = done & ~pwrite;
	assign free_n = 4'(DEPTH_COUNT - r.count);
	assign cur_code = r.word[8*r.code_idx +: 8];
	// direction decode shared by both axes of the running step
	assign cur_dir  = cur_code[7:CODE_DIR];
	assign dx       = dir_dx(cur_dir);
	assign dy       = dir_dy(cur_dir);

	always_comb begin
		next_r = r;
		push = 1'b0;
		pop = 1'b0;
		complete = 1'b0;
		next_r.pix = 1'b0;

		// apb answer: data and error prepared in setup, access phase lasts one cycle
		next_r.rdy = setup;
		next_r.err = 1'b0;                        // error stands only in the access cycle
		if (setup) begin
			next_r.err = 1'b0;
			next_r.rd_ovf = 1'b0;
			next_r.rdata = 32'h0;
			unique case (widx)
				REG_CONTROL_ONE:  next_r.rdata[7:0] = r.control;
				REG_MAP_SELECT:   next_r.rdata[1:0] = r.map_sel;
				REG_QUEUE_STATUS: begin
					next_r.rdata[3:0] = free_n;
					next_r.rdata[QS_OVERFLOW] = r.overflow;
					next_r.rd_ovf = ~pwrite & r.overflow;
				end
				REG_MAP_BASE:     next_r.rdata = r.base[r.map_sel];
				REG_MAP_WIDTH:    next_r.rdata[DIM_W-1:0] = r.width[r.map_sel];
				REG_MAP_HEIGHT:   next_r.rdata[DIM_W-1:0] = r.height[r.map_sel];
				REG_MAP_FORMAT:   next_r.rdata[7:0] = r.format[r.map_sel];
				REG_LINE_ERROR:   next_r.rdata[LINE_W-1:0] = r.line_err;
				REG_LINE_CONST1:  next_r.rdata[LINE_W-1:0] = r.line_one;
				REG_LINE_CONST2:  next_r.rdata[LINE_W-1:0] = r.line_two;
				REG_STEP_LAUNCH:  next_r.rdata = r.steps;
				default:          next_r.err = 1'b1;
			endcase
		end

		// register writes; reserved bits are dropped so they read back as zero
		if (wr) begin
			unique case (widx)
				REG_CONTROL_ONE: if (pstrb[0]) begin
					next_r.control[CTL_IRQ_EN] = pwdata[CTL_IRQ_EN];
					next_r.control[CTL_MASTER] = pwdata[CTL_MASTER];
					next_r.control[CTL_TURBO]  = pwdata[CTL_TURBO];
					next_r.control[CTL_FAST]   = pwdata[CTL_FAST];
					// zero clears, one leaves the status alone
					if (!pwdata[CTL_IRQ_STAT]) begin
						next_r.control[CTL_IRQ_STAT] = 1'b0;
					end
					if (pwdata[CTL_TERM]) begin
						next_r.control[CTL_TERM] = 1'b1;
					end
				end
				REG_MAP_SELECT: if (pstrb[0]) begin
					next_r.map_sel = pwdata[1:0];
				end
				REG_MAP_BASE: begin
					next_r.base[r.map_sel] = merge(r.base[r.map_sel], pwdata, pstrb);
				end
				REG_MAP_WIDTH: begin
					next_r.width[r.map_sel] =
						DIM_W'(merge(32'(r.width[r.map_sel]), pwdata, pstrb));
				end
				REG_MAP_HEIGHT: begin
					next_r.height[r.map_sel] =
						DIM_W'(merge(32'(r.height[r.map_sel]), pwdata, pstrb));
				end
				REG_MAP_FORMAT: if (pstrb[0]) begin
					next_r.format[r.map_sel] = pwdata[7:0] & 8'h8f;
				end
				REG_LINE_ERROR: begin
					next_r.line_err = LINE_W'(merge(32'(r.line_err), pwdata, pstrb));
				end
				REG_LINE_CONST1: begin
					next_r.line_one = LINE_W'(merge(32'(r.line_one), pwdata, pstrb));
				end
				REG_LINE_CONST2: begin
					next_r.line_two = LINE_W'(merge(32'(r.line_two), pwdata, pstrb));
				end
				REG_STEP_LAUNCH: begin
					// the merged word is queued, so earlier low-byte writes ride along
					next_r.steps = merge(r.steps, pwdata, pstrb);
					push = pstrb[3];
				end
				default: ;
			endcase
		end

		// draw-and-step sequencer
		unique case (r.state)
			ST_IDLE: begin
				if (r.control[CTL_TERM]) begin
					next_r.control[CTL_TERM] = 1'b0;
				end else if (r.count != 5'h0) begin
					// a launch taken while busy waits here in the queue
					pop = 1'b1;
					next_r.word = r.queue[r.rd_ptr];
					next_r.code_idx = 2'h0;
					next_r.state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (cur_code == CODE_STOP) begin
					complete = 1'b1;
					next_r.state = ST_IDLE;
				end else begin
					next_r.steps_left = cur_code[3:0];
					next_r.state = ST_RUN;
				end
			end
			ST_RUN: begin
				// sign-extend the unit step so a minus one wraps the position
				next_r.x = r.x + {{(POS_W-2){dx[1]}}, dx};
				next_r.y = r.y + {{(POS_W-2){dy[1]}}, dy};
				next_r.pix = cur_code[CODE_DRAW];
				if (r.steps_left != 4'h0) begin
					next_r.steps_left = r.steps_left - 4'h1;
					// without turbo each step but the last of a code pays an extra datapath clock
					next_r.state = r.control[CTL_TURBO] ? ST_RUN : ST_GAP;
				end else if (r.code_idx == LAST_CODE) begin
					complete = 1'b1;
					next_r.state = ST_IDLE;
				end else begin
					next_r.code_idx = r.code_idx + 2'h1;
					next_r.state = ST_LOAD;
				end
			end
			ST_GAP: begin
				next_r.state = ST_RUN;
			end
			// a corrupted one-hot code falls back to idle instead of locking up
			default: begin
				next_r.state = ST_IDLE;
			end
		endcase

		// terminate aborts the running step and flushes queued launches
		if (r.control[CTL_TERM] && r.state != ST_IDLE) begin
			complete = 1'b0;
			next_r.pix = 1'b0;
			next_r.state = ST_IDLE;
		end
		if (r.control[CTL_TERM]) begin
			pop = 1'b0;
			push = 1'b0;
			next_r.count = 5'h0;
			next_r.rd_ptr = r.wr_ptr;
		end

		// command queue; a push into a full queue is dropped unless a pop frees a slot in the same cycle
		if (push && r.count == DEPTH_COUNT && !pop) begin
			push = 1'b0;
			next_r.overflow = 1'b1;
		end else if (rd && widx == REG_QUEUE_STATUS && r.rd_ovf) begin
			// only the value actually returned is cleared, a fresh one wins
			next_r.overflow = 1'b0;
		end
		if (push) begin
			next_r.queue[r.wr_ptr] = next_r.steps;
			next_r.wr_ptr = (r.wr_ptr == PTR_W'(QUEUE_DEPTH - 1)) ? '0 : r.wr_ptr + 1'b1;
		end
		if (pop) begin
			next_r.rd_ptr = (r.rd_ptr == PTR_W'(QUEUE_DEPTH - 1)) ? '0 : r.rd_ptr + 1'b1;
		end
		if (!r.control[CTL_TERM]) begin
			next_r.count = r.count + 5'(push) - 5'(pop);
		end

		// completion status; set wins over a clearing write in the same cycle
		if (complete) begin
			next_r.control[CTL_IRQ_STAT] = 1'b1;
		end

		// mask map is always one bit per pixel
		next_r.depth = (next_r.map_sel == MAP_MASK) ? DEPTH_1BPP
			: next_r.format[next_r.map_sel][2:0];

		// busy kept as its own flop so the output needs no gate
		next_r.busy = (next_r.state != ST_IDLE);
		// routing bit picks the pin; both pins idle high
		next_r.irq_done_n = ~(next_r.control[CTL_IRQ_STAT]
			& next_r.control[CTL_IRQ_EN]);
		next_r.irq_legacy_n = ~(next_r.control[CTL_IRQ_STAT]
			& ~next_r.control[CTL_IRQ_EN]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.control <= CONTROL_ONE_RESET;
			r.overflow <= QS_OVERFLOW_RESET;
			r.state <= ST_IDLE;
			r.depth <= DEPTH_1BPP;
			r.irq_done_n <= 1'b1;
			r.irq_legacy_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from state flops; irq pins are active low
	assign pready                = r.rdy;
	assign prdata                = r.rdata;
	assign pslverr               = r.err;
	assign engine_done_irq_pin_n = r.irq_done_n;
	assign legacy_irq_pin_n      = r.irq_legacy_n;
	assign master_mode_en        = r.control[CTL_MASTER];
	assign turbo_en              = r.control[CTL_TURBO];
	assign fast_addr_en          = r.control[CTL_FAST];
	assign engine_busy           = r.busy;
	assign pixel_write           = r.pix;
	assign pixel_x               = r.x;
	assign pixel_y               = r.y;
	assign sel_map_depth         = r.depth;
endmodule
`default_nettype wire

// file: verification/draw_engine_setup_regs_props.sv
// checker for the setup register bank: apb answer timing, irq pins, sequencer outputs
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module draw_engine_setup_regs_props
	import draw_engine_pkg::*;
#(
	parameter int QUEUE_DEPTH = 8,
	parameter int POS_W       = 16
) (
	input wire logic             pclk,
	input wire logic             presetn,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [9:0]       paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [3:0]       pstrb,
	input wire logic             pready,
	input wire logic [31:0]      prdata,
	input wire logic             pslverr,
	input wire logic             engine_done_irq_pin_n,
	input wire logic             legacy_irq_pin_n,
	input wire logic             master_mode_en,
	input wire logic             turbo_en,
	input wire logic             fast_addr_en,
	input wire logic             engine_busy,
	input wire logic             pixel_write,
	input wire logic [POS_W-1:0] pixel_x,
	input wire logic [POS_W-1:0] pixel_y,
	input wire logic [2:0]       sel_map_depth
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// top-byte write to the step register, completed this cycle
	logic launch;
	assign launch = psel && penable && pready && pwrite && paddr[9:2] == REG_STEP_LAUNCH && pstrb[3];

	AST_PREADY_ZERO_WAIT: assert property (psel && !penable |=> pready)
		else $error("no answer in the cycle after setup");
	AST_PREADY_CAUSE: assert property (pready |-> $past(psel && !penable))
		else $error("pready without a setup cycle before it");
	AST_SLVERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside an access cycle");
	AST_UNMAPPED_READ_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	AST_IRQ_ONE_PIN: assert property (!(!engine_done_irq_pin_n && !legacy_irq_pin_n))
		else $error("both interrupt pins active");
	AST_PIXEL_WHILE_BUSY: assert property (pixel_write |-> $past(engine_busy))
		else $error("pixel written while sequencer idle");
	AST_UNIT_STEP: assert property (pixel_x == $past(pixel_x) || pixel_x == $past(pixel_x) + 1'b1 || $past(pixel_x) == pixel_x + 1'b1)
		else $error("x position moved by more than one");
	AST_SLOW_GAP: assert property (!turbo_en && $past(!turbo_en) && pixel_write |=> !pixel_write)
		else $error("back-to-back pixels without turbo");
	AST_LAUNCH_STARTS: assert property (launch |-> ##[1:4] engine_busy)
		else $error("launch did not start the sequencer");
endmodule
bind draw_engine_setup_regs draw_engine_setup_regs_props #(.QUEUE_DEPTH(QUEUE_DEPTH), .POS_W(POS_W))
	draw_engine_setup_regs_props_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .engine_done_irq_pin_n(engine_done_irq_pin_n),
	.legacy_irq_pin_n(legacy_irq_pin_n), .master_mode_en(master_mode_en), .turbo_en(turbo_en),
	.fast_addr_en(fast_addr_en), .engine_busy(engine_busy), .pixel_write(pixel_write),
	.pixel_x(pixel_x), .pixel_y(pixel_y), .sel_map_depth(sel_map_depth));
`default_nettype wire

// file: verification/draw_engine_setup_regs_tb_top.sv
// self-checking bench for the setup register bank, driven as an apb master
// assumes the register indices of the package; checks each apb answer comes one cycle after setup
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module draw_engine_setup_regs_tb_top;
	import draw_engine_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, rdy, err;
	logic [9:0]  paddr;
	logic [31:0] pwdata, rd;
	logic [3:0]  pstrb;
	logic        pready, pslverr, done_n, legacy_n, master, turbo, fast, busy, pixel_write;
	logic [31:0] prdata;
	logic [15:0] pixel_x, pixel_y;
	logic [2:0]  sel_map_depth;
	logic [2:0]  depths [4] = '{DEPTH_8BPP, DEPTH_1BPP, DEPTH_16BPP, DEPTH_32BPP}; // map a is the mask, forced to 1bpp
	int          n_errors = 0, n_checks = 0, cycles = 0, n_pix = 0;
	draw_engine_setup_regs draw_engine_setup_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .engine_done_irq_pin_n(done_n),
		.legacy_irq_pin_n(legacy_n), .master_mode_en(master), .turbo_en(turbo),
		.fast_addr_en(fast), .engine_busy(busy), .pixel_write(pixel_write), .pixel_x(pixel_x),
		.pixel_y(pixel_y), .sel_map_depth(sel_map_depth));
	always #2 pclk = ~pclk;
	// pulse counter and hang guard; run needs well under 3000 cycles
	always @(posedge pclk) begin
		cycles++;
		if (pixel_write === 1'b1) n_pix++;
		if (cycles == 5000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// one apb transfer; answer taken at the rising edge where pready is high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d; pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		rdy = 1'b0;
		// waits as long as it takes; only the cycle ceiling ends a hang
		while (rdy !== 1'b1) begin
			@(posedge pclk);
			rdy = pready; rd = prdata; err = pslverr; t++;
		end
		`CHK(t, 1) // zero wait states promised
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, idx, d, s);
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0, 4'h0);
		`CHK(rd, exp)
	endtask
	// sequencer pops one cycle after the push, so wait before polling busy
	task automatic wait_idle();
		int t;
		repeat (4) @(posedge pclk);
		for (t = 0; t < 600 && busy !== 1'b0; t++) @(negedge pclk);
		`CHK(busy, 1'b0)
		repeat (3) @(negedge pclk);
	endtask
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 10'h000; pwdata = 32'h0; pstrb = 4'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(REG_CONTROL_ONE, 32'h0);
		rd_chk(REG_QUEUE_STATUS, 32'h8);
		wr(REG_QUEUE_STATUS, 32'hffff_ffff, 4'hf);
		rd_chk(REG_QUEUE_STATUS, 32'h8);
		rd_chk(8'h11, 32'h0);
		`CHK(err, 1'b1)
		// per-map registers, reserved bits dropped, mask depth forced
		for (int m = 0; m < 4; m++) begin
			wr(REG_MAP_SELECT, 32'hfc | 32'(m), 4'hf);
			rd_chk(REG_MAP_SELECT, 32'(m));
			wr(REG_MAP_BASE, 32'h1234_5670 + 32'(m), 4'hf);
			wr(REG_MAP_WIDTH, 32'hffff_ff00 | 32'(m), 4'hf);
			wr(REG_MAP_HEIGHT, 32'h0000_f120 | 32'(m), 4'hf);
			wr(REG_MAP_FORMAT, 32'hffff_fff8 | {29'h0, depths[m]}, 4'hf);
			rd_chk(REG_MAP_WIDTH, 32'h0000_0f00 | 32'(m));
			rd_chk(REG_MAP_HEIGHT, 32'h0000_0120 | 32'(m));
			rd_chk(REG_MAP_FORMAT, 32'h88 | {29'h0, depths[m]});
			`CHK(sel_map_depth, (m == 0) ? DEPTH_1BPP : depths[m])
		end
		for (int m = 0; m < 4; m++) begin
			wr(REG_MAP_SELECT, 32'(m), 4'hf);
			rd_chk(REG_MAP_BASE, 32'h1234_5670 + 32'(m));
		end
		wr(REG_LINE_ERROR, 32'hffff_ffff, 4'hf);
		wr(REG_LINE_CONST1, 32'hffff_ffff, 4'hf);
		wr(REG_LINE_CONST2, 32'hffff_dfff, 4'hf);
		rd_chk(REG_LINE_ERROR, 32'h3fff);
		rd_chk(REG_LINE_CONST1, 32'h3fff);
		rd_chk(REG_LINE_CONST2, 32'h1fff);
		// two drawn +x steps, completion routed to the legacy pin
		wr(REG_STEP_LAUNCH, 32'h0000_0011, 4'hf);
		wait_idle();
		`CHK(n_pix, 2)
		`CHK(pixel_x, 16'd2)
		`CHK({done_n, legacy_n}, 2'b10)
		rd_chk(REG_CONTROL_ONE, 32'h10);
		wr(REG_CONTROL_ONE, 32'h01, 4'hf);
		rd_chk(REG_CONTROL_ONE, 32'h01);
		// low bytes only load; top byte alone launches the merged word
		wr(REG_STEP_LAUNCH, 32'h0000_90c3, 4'h3);
		repeat (8) @(negedge pclk);
		`CHK(busy, 1'b0)
		wr(REG_STEP_LAUNCH, 32'h0, 4'h8);
		wait_idle();
		`CHK(n_pix, 3)
		`CHK({pixel_x, pixel_y}, {16'd1, 16'd4})
		`CHK({done_n, legacy_n}, 2'b01)
		wr(REG_CONTROL_ONE, 32'h11, 4'hf);
		rd_chk(REG_CONTROL_ONE, 32'h11);
		// turbo: four back-to-back drawn steps
		wr(REG_CONTROL_ONE, 32'hc2, 4'hf); // host taken as pci, master mode allowed
		@(negedge pclk);
		`CHK({master, turbo, fast}, 3'b111)
		wr(REG_STEP_LAUNCH, 32'h0000_0013, 4'hf);
		wait_idle();
		`CHK(n_pix, 7)
		`CHK(pixel_x, 16'd5)
		wr(REG_CONTROL_ONE, 32'h00, 4'hf);
		// long moves fill the queue until writes are dropped, then abort
		for (int i = 0; i < 11; i++) wr(REG_STEP_LAUNCH, 32'h0f0f_0f0f, 4'hf);
		rd_chk(REG_QUEUE_STATUS, 32'h80);
		rd_chk(REG_QUEUE_STATUS, 32'h00);
		wr(REG_CONTROL_ONE, 32'h20, 4'hf);
		wait_idle();
		rd_chk(REG_CONTROL_ONE, 32'h00);
		rd_chk(REG_QUEUE_STATUS, 32'h08);
		final_report();
	end
endmodule
`default_nettype wire
